/* verilog/lcr_regs.v */
// Two-wire serial slave with the low control register bank of the nine-output LED driver.
//
// How it works
// - All control state is byte registers, read and written over the two-wire port.
// - Register 0x00 bit 6 is device enable, reset 0, writing 1 enables.
// - Register 0x00 holds sequencer run fields at 5:4, 3:2, 1:0, reset 00.
// - Register 0x01 holds sequencer mode fields at 5:4, 3:2, 1:0, reset 00.
// - Register 0x02 bit 0 enables ratiometric dimming for output nine, reset 0.
// - Register 0x03 bit n-1 enables ratiometric dimming for output n, reset 0.
// - Register 0x04 bit 0 switches output nine on, resets to 1.
`timescale 1ns/100ps
`default_nettype none
`include "lcr_defs.vh"
module lcr_regs (
    input  wire       i_clock,
    input  wire       i_rstn,
    input  wire       i_scl,
    input  wire       i_sda,
    input  wire [1:0] i_addr_sel,
    input  wire       i_auto_incr_en,
    output reg        o_sda_out,
    output reg        o_sda_oe,
    output wire       o_chip_enable,
    output wire [1:0] o_seq1_run_control,
    output wire [1:0] o_seq2_run_control,
    output wire [1:0] o_seq3_run_control,
    output wire [1:0] o_seq1_mode_select,
    output wire [1:0] o_seq2_mode_select,
    output wire [1:0] o_seq3_mode_select,
    output wire [8:0] o_out_ratiometric,
    output wire       o_out9_switch
);
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_ADDR  = 4'h1;
    localparam [3:0] ST_REG   = 4'h2;
    localparam [3:0] ST_WDATA = 4'h3;
    localparam [3:0] ST_ACK   = 4'h4;
    localparam [3:0] ST_RDATA = 4'h5;
    localparam [3:0] ST_MACK  = 4'h6;
    localparam [3:0] ST_RLOAD = 4'h7;

    wire [3:0] pins_sync;
    wire       scl_s;
    wire       sda_s;
    wire [1:0] asel_s;

    reg        scl_prev_reg;
    reg        sda_prev_reg;
    reg [3:0]  state_reg;
    reg [3:0]  after_ack_reg;
    reg [2:0]  bit_cnt_reg;
    reg [7:0]  shift_reg;
    reg [7:0]  ptr_reg;
    reg [7:0]  enable_run_reg;
    reg [7:0]  seq_mode_reg;
    reg [7:0]  ratio_high_reg;
    reg [7:0]  ratio_low_reg;
    reg [7:0]  onoff_high_reg;
    reg [7:0]  rd_byte;

    wire       scl_rise;
    wire       scl_fall;
    wire       start_cond;
    wire       stop_cond;
    wire [7:0] rx_byte;
    wire [6:0] dev_addr;

    lcr_pin_sync #(
        .WIDTH   (4),
        .RST_VAL (4'hf)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async ({i_addr_sel, i_scl, i_sda}),
        .o_sync  (pins_sync)
    );

    assign asel_s     = pins_sync[3:2];
    assign scl_s      = pins_sync[1];
    assign sda_s      = pins_sync[0];
    assign scl_rise   = scl_s & ~scl_prev_reg;
    assign scl_fall   = ~scl_s & scl_prev_reg;
    assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    assign rx_byte    = {shift_reg[6:0], sda_s};
    assign dev_addr   = `LCR_DEV_ADDR_BASE + {5'h00, asel_s};

    // Field outputs come straight from the register flip-flops.
    assign o_chip_enable      = enable_run_reg[`LCR_CHIP_EN_BIT];
    assign o_seq1_run_control = enable_run_reg[`LCR_SEQ1_MSB:`LCR_SEQ1_LSB];
    assign o_seq2_run_control = enable_run_reg[`LCR_SEQ2_MSB:`LCR_SEQ2_LSB];
    assign o_seq3_run_control = enable_run_reg[`LCR_SEQ3_MSB:`LCR_SEQ3_LSB];
    assign o_seq1_mode_select = seq_mode_reg[`LCR_SEQ1_MSB:`LCR_SEQ1_LSB];
    assign o_seq2_mode_select = seq_mode_reg[`LCR_SEQ2_MSB:`LCR_SEQ2_LSB];
    assign o_seq3_mode_select = seq_mode_reg[`LCR_SEQ3_MSB:`LCR_SEQ3_LSB];
    assign o_out_ratiometric  = {ratio_high_reg[`LCR_OUT9_BIT], ratio_low_reg};
    assign o_out9_switch      = onoff_high_reg[`LCR_OUT9_BIT];

    // Read data mux; offsets outside this bank read as zero.
    always @* begin
        case (ptr_reg)
            `LCR_OFS_ENABLE_RUN: rd_byte = enable_run_reg;
            `LCR_OFS_SEQ_MODE:   rd_byte = seq_mode_reg;
            `LCR_OFS_RATIO_HIGH: rd_byte = ratio_high_reg;
            `LCR_OFS_RATIO_LOW:  rd_byte = ratio_low_reg;
            `LCR_OFS_ONOFF_HIGH: rd_byte = onoff_high_reg;
            default:             rd_byte = 8'h00;
        endcase
    end

    // Register writes; reserved bits are masked so they stay zero.
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            enable_run_reg <= `LCR_RST_ENABLE_RUN;
            seq_mode_reg   <= `LCR_RST_SEQ_MODE;
            ratio_high_reg <= `LCR_RST_RATIO_HIGH;
            ratio_low_reg  <= `LCR_RST_RATIO_LOW;
            onoff_high_reg <= `LCR_RST_ONOFF_HIGH;
        end else if (!start_cond && !stop_cond && scl_rise && state_reg == ST_WDATA
                     && bit_cnt_reg == 3'h7) begin
            case (ptr_reg)
                `LCR_OFS_ENABLE_RUN: enable_run_reg <= rx_byte & `LCR_MASK_ENABLE_RUN;
                `LCR_OFS_SEQ_MODE:   seq_mode_reg   <= rx_byte & `LCR_MASK_SEQ_MODE;
                `LCR_OFS_RATIO_HIGH: ratio_high_reg <= rx_byte & `LCR_MASK_RATIO_HIGH;
                `LCR_OFS_RATIO_LOW:  ratio_low_reg  <= rx_byte & `LCR_MASK_RATIO_LOW;
                `LCR_OFS_ONOFF_HIGH: onoff_high_reg <= rx_byte & `LCR_MASK_ONOFF_HIGH;
                default:             ratio_low_reg  <= ratio_low_reg;
            endcase
        end
    end

    // Serial slave: byte framing, acknowledge and read shifting.
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_prev_reg  <= 1'b1;
            sda_prev_reg  <= 1'b1;
            state_reg     <= ST_IDLE;
            after_ack_reg <= ST_IDLE;
            bit_cnt_reg   <= 3'h0;
            shift_reg     <= 8'h00;
            ptr_reg       <= 8'h00;
            o_sda_out     <= 1'b0;
            o_sda_oe      <= 1'b0;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            if (start_cond) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 3'h0;
                o_sda_oe    <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                o_sda_oe  <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        o_sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_reg   <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7) begin
                                state_reg <= ST_ACK;
                                if (state_reg == ST_ADDR) begin
                                    after_ack_reg <= rx_byte[0] ? ST_RLOAD : ST_REG;
                                    if (rx_byte[7:1] != dev_addr) begin
                                        state_reg <= ST_IDLE;
                                    end
                                end else if (state_reg == ST_REG) begin
                                    ptr_reg       <= rx_byte;
                                    after_ack_reg <= ST_WDATA;
                                end else begin
                                    after_ack_reg <= ST_WDATA;
                                    if (i_auto_incr_en) begin
                                        ptr_reg <= ptr_reg + 8'h01;
                                    end
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        // Ack is driven from the fall after the eighth bit to the next fall.
                        if (scl_fall) begin
                            if (!o_sda_oe) begin
                                o_sda_oe <= 1'b1;
                            end else if (after_ack_reg == ST_RLOAD) begin
                                o_sda_oe    <= ~rd_byte[7];
                                shift_reg   <= {rd_byte[6:0], 1'b0};
                                bit_cnt_reg <= 3'h0;
                                state_reg   <= ST_RDATA;
                            end else begin
                                o_sda_oe    <= 1'b0;
                                bit_cnt_reg <= 3'h0;
                                state_reg   <= after_ack_reg;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7) begin
                                state_reg <= ST_MACK;
                            end
                        end else if (scl_fall) begin
                            o_sda_oe  <= ~shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                    ST_MACK: begin
                        if (scl_fall) begin
                            o_sda_oe <= 1'b0;
                        end else if (scl_rise) begin
                            if (!sda_s) begin
                                ptr_reg   <= ptr_reg + 8'h01;
                                state_reg <= ST_RLOAD;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_RLOAD: begin
                        if (scl_fall) begin
                            o_sda_oe    <= ~rd_byte[7];
                            shift_reg   <= {rd_byte[6:0], 1'b0};
                            bit_cnt_reg <= 3'h0;
                            state_reg   <= ST_RDATA;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        o_sda_oe  <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* common/lcr_defs.vh */
// Register offsets, field positions, masks, reset values and bus constants of the control bank.
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH

`define LCR_OFS_ENABLE_RUN      8'h00
`define LCR_OFS_SEQ_MODE        8'h01
`define LCR_OFS_RATIO_HIGH      8'h02
`define LCR_OFS_RATIO_LOW       8'h03
`define LCR_OFS_ONOFF_HIGH      8'h04

`define LCR_CHIP_EN_BIT         6
`define LCR_SEQ1_MSB            5
`define LCR_SEQ1_LSB            4
`define LCR_SEQ2_MSB            3
`define LCR_SEQ2_LSB            2
`define LCR_SEQ3_MSB            1
`define LCR_SEQ3_LSB            0
`define LCR_OUT9_BIT            0

`define LCR_MASK_ENABLE_RUN     8'h7f
`define LCR_MASK_SEQ_MODE       8'h3f
`define LCR_MASK_RATIO_HIGH     8'h01
`define LCR_MASK_RATIO_LOW      8'hff
`define LCR_MASK_ONOFF_HIGH     8'h01

`define LCR_RST_ENABLE_RUN      8'h00
`define LCR_RST_SEQ_MODE        8'h00
`define LCR_RST_RATIO_HIGH      8'h00
`define LCR_RST_RATIO_LOW       8'h00
`define LCR_RST_ONOFF_HIGH      8'h01

`define LCR_DEV_ADDR_BASE       7'h32

`endif

/* verilog/lcr_pin_sync.v */
// Three-stage pin synchroniser whose output follows once the last two stages agree.
`timescale 1ns/100ps
`default_nettype none
module lcr_pin_sync #(
    parameter WIDTH   = 4,
    parameter RST_VAL = 4'hf
) (
    input  wire             i_clock,
    input  wire             i_rstn,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;
    genvar g;

    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            stage1_reg <= RST_VAL;
            stage2_reg <= RST_VAL;
            stage3_reg <= RST_VAL;
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always @(posedge i_clock or negedge i_rstn) begin
                if (!i_rstn) begin
                    o_sync[g] <= RST_VAL[g];
                end else if (stage2_reg[g] == stage3_reg[g]) begin
                    o_sync[g] <= stage3_reg[g];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* tb/lcr_host_model.sv */
// Host model that drives the two-wire port of the control bank.
`timescale 1ns/100ps
`default_nettype none
module lcr_host_model (
    input  wire logic i_clock,
    input  wire logic i_sda_wire,
    output var  logic o_scl,
    output var  logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    // Start when stop is low, stop when it is high; SCL phases of 20 clocks clear the sync.
    task automatic cond(input logic stop);
        o_sda = ~stop;
        tick(10);
        o_scl = 1'b1;
        tick(20);
        o_sda = stop;
        tick(20);
        o_scl = stop;
        tick(10);
    endtask
    task automatic bit_x(input logic b, output logic r);
        o_sda = b;
        tick(10);
        o_scl = 1'b1;
        tick(20);
        r = i_sda_wire;
        o_scl = 1'b0;
        tick(10);
    endtask
    task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] q,
                          output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            // Bits go back raw; the host bases nothing on reserved ones.
            q[i] = r;
        end
        bit_x(~mack, r);
        ack = ~r;
    endtask
endmodule
`default_nettype wire

/* tb/lcr_regs_sva.sv */
// Port checker for the low control register bank.
`timescale 1ns/100ps
`default_nettype none
module lcr_regs_sva (
    input wire logic       i_clock,
    input wire logic       i_rstn,
    input wire logic       i_scl,
    input wire logic       o_sda_out,
    input wire logic       o_sda_oe,
    input wire logic       o_chip_enable,
    input wire logic [1:0] o_seq1_run_control,
    input wire logic [1:0] o_seq2_run_control,
    input wire logic [1:0] o_seq3_run_control,
    input wire logic [1:0] o_seq1_mode_select,
    input wire logic [1:0] o_seq2_mode_select,
    input wire logic [1:0] o_seq3_mode_select,
    input wire logic [8:0] o_out_ratiometric,
    input wire logic       o_out9_switch
);
    wire [6:0]  run_f = {o_chip_enable, o_seq1_run_control, o_seq2_run_control,
                         o_seq3_run_control};
    wire [5:0]  mode_f = {o_seq1_mode_select, o_seq2_mode_select, o_seq3_mode_select};
    wire [22:0] all_f = {run_f, mode_f, o_out_ratiometric, o_out9_switch};
    default clocking cb @(posedge i_clock); endclocking
    a_sda_out_low: assert property (disable iff (!i_rstn) o_sda_out == 1'b0)
        else $error("data pin output not low");
    a_reset_run: assert property (!i_rstn |-> run_f == 7'h00)
        else $error("enable or run field not cleared by reset");
    a_reset_mode: assert property (!i_rstn |-> mode_f == 6'h00)
        else $error("mode field not cleared by reset");
    a_reset_ratio: assert property (!i_rstn |-> o_out_ratiometric == 9'h000)
        else $error("dimming enable not cleared by reset");
    a_reset_switch: assert property (!i_rstn |-> o_out9_switch)
        else $error("output nine not on in reset");
    a_update_scl_high: assert property (disable iff (!i_rstn)
        !$stable(all_f) |-> i_scl && $past(i_scl, 2)) else $error("field changed outside write");
    a_oe_scl_low: assert property (disable iff (!i_rstn)
        !$stable(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
        else $error("data changed with clock high");
    a_oe_holds: assert property (disable iff (!i_rstn)
        $changed(o_sda_oe) |=> $stable(o_sda_oe) [*8]) else $error("data bit too short");
    c_enable_set: cover property (disable iff (!i_rstn) $rose(o_chip_enable));
    c_ack_driven: cover property (disable iff (!i_rstn) $rose(o_sda_oe));
    c_switch_off: cover property (disable iff (!i_rstn) $fell(o_out9_switch));
endmodule
bind lcr_regs lcr_regs_sva lcr_regs_sva_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_scl(i_scl), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_chip_enable(o_chip_enable), .o_seq1_run_control(o_seq1_run_control),
    .o_seq2_run_control(o_seq2_run_control), .o_seq3_run_control(o_seq3_run_control),
    .o_seq1_mode_select(o_seq1_mode_select), .o_seq2_mode_select(o_seq2_mode_select),
    .o_seq3_mode_select(o_seq3_mode_select), .o_out_ratiometric(o_out_ratiometric),
    .o_out9_switch(o_out9_switch));
`default_nettype wire

/* tb/test_lcr_regs.sv */
// Self-checking bench for the low control register bank, driven as a two-wire host.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_lcr_regs;
    logic       i_clock, i_rstn, i_auto_incr_en, scl, msda, ack;
    logic [1:0] i_addr_sel;
    logic [7:0] q;
    wire        sda_oe, sda_out, chip_en, out9;
    wire [1:0]  run1, run2, run3, mode1, mode2, mode3;
    wire [8:0]  ratio;
    wire        sda_wire = sda_oe ? sda_out : msda;
    int         n_mismatch, total_checks;
    lcr_regs lcr_regs_inst (.i_clock(i_clock), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_wire),
        .i_addr_sel(i_addr_sel), .i_auto_incr_en(i_auto_incr_en), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .o_chip_enable(chip_en), .o_seq1_run_control(run1),
        .o_seq2_run_control(run2), .o_seq3_run_control(run3), .o_seq1_mode_select(mode1),
        .o_seq2_mode_select(mode2), .o_seq3_mode_select(mode3), .o_out_ratiometric(ratio),
        .o_out9_switch(out9));
    lcr_host_model lcr_host_model_inst (.i_clock(i_clock), .i_sda_wire(sda_wire), .o_scl(scl),
        .o_sda(msda));
    task automatic cond(input logic stop);
        lcr_host_model_inst.cond(stop);
    endtask
    task automatic put(input logic [7:0] b);
        lcr_host_model_inst.byte_x(b, 1'b0, q, ack);
        `CHK(ack, 1'b1)
    endtask
    task automatic get(input logic [7:0] exp, input logic mack);
        lcr_host_model_inst.byte_x(8'hff, mack, q, ack);
        `CHK(q, exp)
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        cond(1'b0);
        put(8'h66);
        put(ptr);
        put(d);
        cond(1'b1);
    endtask
    task automatic rd_all(input logic [7:0] e [6]);
        cond(1'b0);
        put(8'h66);
        put(8'h00);
        cond(1'b0);
        put(8'h67);
        for (int i = 0; i < 6; i++) get(e[i], i < 5);
        cond(1'b1);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        i_rstn = 1'b1;
        i_addr_sel = 2'b01;
        // Reset falls after time zero so every flop sees the edge before the first clock.
        #1 i_rstn = 1'b0;
        i_auto_incr_en = 1'b1;
        repeat (16) @(negedge i_clock);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clock);
        rd_all('{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
        cond(1'b0);
        lcr_host_model_inst.byte_x(8'h64, 1'b0, q, ack);
        `CHK(ack, 1'b0)
        cond(1'b1);
        cond(1'b0);
        put(8'h66);
        put(8'h00);
        for (int i = 0; i < 4; i++) put(8'hff);
        put(8'h00);
        cond(1'b1);
        `CHK({chip_en, run1, run2, run3}, 7'h7f)
        `CHK({mode1, mode2, mode3}, 6'h3f)
        `CHK(ratio, 9'h1ff)
        `CHK(out9, 1'b0)
        rd_all('{8'h7f, 8'h3f, 8'h01, 8'hff, 8'h00, 8'h00});
        i_auto_incr_en = 1'b0;
        cond(1'b0);
        put(8'h66);
        put(8'h00);
        put(8'h40);
        put(8'h1b);
        cond(1'b1);
        `CHK({chip_en, run1, run2, run3}, 7'h1b)
        wr(8'h01, 8'h2d);
        `CHK({mode1, mode2, mode3}, 6'h2d)
        for (int n = 0; n < 8; n++) begin
            wr(8'h03, 8'h01 << n);
            `CHK(ratio, {1'b1, 8'h01 << n})
        end
        wr(8'h02, 8'hfe);
        `CHK(ratio[8], 1'b0)
        wr(8'h04, 8'hff);
        `CHK(out9, 1'b1)
        rd_all('{8'h1b, 8'h2d, 8'h00, 8'h80, 8'h01, 8'h00});
        i_rstn = 1'b0;
        repeat (2) @(negedge i_clock);
        `CHK({chip_en, run1, run2, run3, mode1, mode2, mode3}, 13'h0000)
        `CHK({ratio, out9}, 10'h001)
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clock);
        rd_all('{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
        wrap_up();
    end
endmodule
`default_nettype wire
